/* File: verilog/tx_pcs_pkg.sv */
// Purpose: Shared types and constants for the 100 Mb/s transmit coding path.
// Assumes: One 250 MHz clock; serial line bits run at 125 Mb/s.
// Notes:   Code-group values are the line code's own constants.
`default_nettype none
package tx_pcs_pkg;

	// **********************************************
	// Timing
	// **********************************************
	localparam int MCLK_PERIOD_PS = 4000;
	localparam int BIT_PERIOD_PS  = 8000;
	localparam int BIT_DIV        = (BIT_PERIOD_PS + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
	localparam logic [0:0] DIV_LAST      = 1'(BIT_DIV - 1);
	localparam logic [2:0] GROUP_BITS    = 3'h5;
	localparam logic [1:0] SEED_LOAD_CYC = 2'h3;

	// **********************************************
	// Code-groups
	// **********************************************
	localparam logic [4:0] CG_IDLE = 5'h1f;
	localparam logic [4:0] CG_J    = 5'h18;
	localparam logic [4:0] CG_K    = 5'h11;
	localparam logic [4:0] CG_T    = 5'h0d;
	localparam logic [4:0] CG_R    = 5'h07;
	localparam logic [15:0][4:0] DATA_CODE_TABLE = {
		5'h1d, 5'h1c, 5'h1b, 5'h1a, 5'h17, 5'h16, 5'h13, 5'h12,
		5'h0f, 5'h0e, 5'h0b, 5'h0a, 5'h15, 5'h14, 5'h09, 5'h1e};

	// **********************************************
	// Scrambler
	// **********************************************
	localparam int          LFSR_WIDTH = 11;
	localparam logic [6:0]  SEED_LOW   = 7'h5a;

	// **********************************************
	// Types
	// **********************************************
	typedef enum logic [1:0] {ST_IDLE, ST_SSD_K, ST_DATA, ST_ESD_R} enc_state_type;

	typedef struct packed {
		logic       tx_en;
		logic [3:0] txd;
	} mii_tx_type;

	typedef struct packed {
		logic bit_strobe;
		logic nrz_bit;
		logic drive_pos;
		logic drive_neg;
	} line_out_type;

endpackage
`default_nettype wire

/* File: verilog/fast_ethernet_tx_pcs_encoder.sv */
// Purpose: 4B/5B encode, delimit, scramble, NRZI and MLT-3 split of MII transmit data.
// Assumes: MII inputs, straps and bypass levels are asynchronous to mclk.
// Notes:   Nibbles are taken on rising edges of tx_clk seen through a synchroniser.
`timescale 1ns/1ps
`default_nettype none
module fast_ethernet_tx_pcs_encoder (
	// Clock and reset
	input  wire logic                       mclk,
	input  wire logic                       sys_rst,
	// MII transmit side
	input  wire logic                       tx_clk,
	input  wire tx_pcs_pkg::mii_tx_type     mii_tx,
	// Straps and stage bypass levels
	input  wire logic [4:0]                 phy_address_straps,
	input  wire logic                       bypass_encoder,
	input  wire logic                       bypass_scrambler,
	// Line driver side
	output var  tx_pcs_pkg::line_out_type   line_out
);

	// **********************************************
	// State
	// **********************************************
	typedef struct packed {
		tx_pcs_pkg::mii_tx_type                 mii_s1;
		tx_pcs_pkg::mii_tx_type                 mii_s2;
		logic                                   clk_s1;
		logic                                   clk_s2;
		logic                                   clk_s3;
		logic [1:0]                             cfg_s1;
		logic [1:0]                             cfg_s2;
		logic [4:0]                             strap_s1;
		logic [4:0]                             strap_s2;
		logic [1:0]                             seed_wait;
		tx_pcs_pkg::enc_state_type              fsm;
		logic [4:0]                             shreg;
		logic [2:0]                             bits_left;
		logic [0:0]                             div;
		logic [tx_pcs_pkg::LFSR_WIDTH-1:0]      lfsr;
		logic                                   nrzi;
		logic [1:0]                             phase;
		tx_pcs_pkg::line_out_type               line;
	} core_type;

	core_type   r;
	core_type   next_r;
	logic       tick;
	logic       nib;
	logic [4:0] group;
	logic       nrz;
	logic       scr;
	logic       bit_go;

	assign tick   = (r.div == tx_pcs_pkg::DIV_LAST);
	// The tx_clk history is zero after reset whatever the pin holds, so a high pin would
	// pass for an edge; nibbles are ignored until the seed load has also ended
	assign nib    = r.clk_s2 & ~r.clk_s3 & (r.seed_wait == tx_pcs_pkg::SEED_LOAD_CYC);
	assign bit_go = !nib && tick && (r.bits_left != 3'h0);
	assign nrz    = r.shreg[4];
	// Feedback x^11 + x^9 + 1 taken from the register itself, closed loop
	assign scr    = r.lfsr[10] ^ r.lfsr[8];

	// **********************************************
	// Code-group choice
	// **********************************************
	always_comb begin
		group = tx_pcs_pkg::CG_IDLE;
		case (r.fsm)
			tx_pcs_pkg::ST_IDLE: begin
				if (r.mii_s2.tx_en) begin
					group = tx_pcs_pkg::CG_J;
				end
			end
			tx_pcs_pkg::ST_SSD_K: begin
				group = tx_pcs_pkg::CG_K;
			end
			tx_pcs_pkg::ST_DATA: begin
				if (!r.mii_s2.tx_en) begin
					group = tx_pcs_pkg::CG_T;
				end else if (r.cfg_s2[0]) begin
					group = {1'b0, r.mii_s2.txd};
				end else begin
					group = tx_pcs_pkg::DATA_CODE_TABLE[r.mii_s2.txd];
				end
			end
			tx_pcs_pkg::ST_ESD_R: begin
				group = tx_pcs_pkg::CG_R;
			end
			default: begin
				group = tx_pcs_pkg::CG_IDLE;
			end
		endcase
	end

	// **********************************************
	// Next state
	// **********************************************
	always_comb begin
		next_r                 = r;
		next_r.mii_s1          = mii_tx;
		next_r.mii_s2          = r.mii_s1;
		next_r.clk_s1          = tx_clk;
		next_r.clk_s2          = r.clk_s1;
		next_r.clk_s3          = r.clk_s2;
		next_r.cfg_s1          = {bypass_scrambler, bypass_encoder};
		next_r.cfg_s2          = r.cfg_s1;
		next_r.strap_s1        = phy_address_straps;
		next_r.strap_s2        = r.strap_s1;
		next_r.div             = tick ? 1'h0 : r.div + 1'h1;
		next_r.line.bit_strobe = 1'b0;
		// Straps need two cycles through the synchroniser before the seed is good
		if (r.seed_wait != tx_pcs_pkg::SEED_LOAD_CYC) begin
			next_r.seed_wait = r.seed_wait + 2'h1;
			next_r.lfsr      = {r.strap_s2[4:1], tx_pcs_pkg::SEED_LOW};
		end
		if (nib) begin
			next_r.shreg     = group;
			next_r.bits_left = tx_pcs_pkg::GROUP_BITS;
			case (r.fsm)
				tx_pcs_pkg::ST_IDLE: begin
					if (r.mii_s2.tx_en) begin
						next_r.fsm = tx_pcs_pkg::ST_SSD_K;
					end
				end
				tx_pcs_pkg::ST_SSD_K: begin
					next_r.fsm = tx_pcs_pkg::ST_DATA;
				end
				tx_pcs_pkg::ST_DATA: begin
					if (!r.mii_s2.tx_en) begin
						next_r.fsm = tx_pcs_pkg::ST_ESD_R;
					end
				end
				default: begin
					next_r.fsm = tx_pcs_pkg::ST_IDLE;
				end
			endcase
		end else if (bit_go) begin
			next_r.shreg           = {r.shreg[3:0], 1'b0};
			next_r.bits_left       = r.bits_left - 3'h1;
			next_r.lfsr            = {r.lfsr[9:0], scr};
			next_r.line.bit_strobe = 1'b1;
			next_r.line.nrz_bit    = r.cfg_s2[1] ? nrz : nrz ^ scr;
			next_r.nrzi            = r.nrzi ^ next_r.line.nrz_bit;
			// Each change of the NRZI line steps the three-level code on
			if (next_r.nrzi != r.nrzi) begin
				next_r.phase = r.phase + 2'h1;
			end
			// Only three levels ever leave the block, never a binary drive
			next_r.line.drive_pos = (next_r.phase == 2'h1);
			next_r.line.drive_neg = (next_r.phase == 2'h3);
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign line_out = r.line;

	// **********************************************
	// Checks
	// **********************************************
	a_ssd_first: assert property (@(posedge mclk) disable iff (sys_rst)
		nib && r.fsm == tx_pcs_pkg::ST_IDLE && r.mii_s2.tx_en
		|=> r.shreg == tx_pcs_pkg::CG_J && r.fsm == tx_pcs_pkg::ST_SSD_K)
		else $error("start delimiter J not loaded");
	a_ssd_second: assert property (@(posedge mclk) disable iff (sys_rst)
		nib && r.fsm == tx_pcs_pkg::ST_SSD_K |=> r.shreg == tx_pcs_pkg::CG_K)
		else $error("start delimiter K not loaded");
	a_data_code: assert property (@(posedge mclk) disable iff (sys_rst)
		nib && r.fsm == tx_pcs_pkg::ST_DATA && r.mii_s2.tx_en && !r.cfg_s2[0]
		&& r.mii_s2.txd == 4'h0 |=> r.shreg == 5'h1e)
		else $error("nibble zero not coded 11110");
	a_esd_pair: assert property (@(posedge mclk) disable iff (sys_rst)
		nib && r.fsm == tx_pcs_pkg::ST_DATA && !r.mii_s2.tx_en
		|=> r.shreg == tx_pcs_pkg::CG_T && r.fsm == tx_pcs_pkg::ST_ESD_R)
		else $error("end delimiter T missing");
	a_idle_fill: assert property (@(posedge mclk) disable iff (sys_rst)
		nib && r.fsm == tx_pcs_pkg::ST_IDLE && !r.mii_s2.tx_en
		|=> r.shreg == tx_pcs_pkg::CG_IDLE && r.fsm == tx_pcs_pkg::ST_IDLE)
		else $error("idle not sent between frames");
	a_scram_xor: assert property (@(posedge mclk) disable iff (sys_rst)
		bit_go && !r.cfg_s2[1] |=> line_out.nrz_bit == ($past(nrz) ^ $past(scr)))
		else $error("scrambled bit wrong");
	a_mlt_levels: assert property (@(posedge mclk) disable iff (sys_rst)
		!(line_out.drive_pos && line_out.drive_neg))
		else $error("both drive streams high");
	a_mlt_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		bit_go ##1 !line_out.nrz_bit |-> $stable(r.phase))
		else $error("MLT-3 level moved on zero");
	// First strobe lands one or two cycles after the load, by divider phase
	a_bit_burst: assert property (@(posedge mclk) disable iff (sys_rst)
		nib |=> (r.bits_left == 3'h5 && !line_out.bit_strobe)
		##[1:2] (r.bits_left == 3'h4 && line_out.bit_strobe))
		else $error("code-group not serialised in order");
	a_seed_load: assert property (@(posedge mclk) disable iff (sys_rst)
		$rose(r.seed_wait == tx_pcs_pkg::SEED_LOAD_CYC)
		|-> r.lfsr[10:7] == $past(r.strap_s2[4:1]))
		else $error("seed not from straps");

endmodule
`default_nettype wire

/* File: verif/mac_model.sv */
// Purpose: MAC side of the MII transmit interface.
// Assumes: Free-running 125 ns transmit clock, as MII transmit clocks run between frames.
// Notes:   Enable and nibble change at the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module mac_model (
	// MII transmit side
	output logic                   tx_clk,
	output tx_pcs_pkg::mii_tx_type mii_tx
);
	initial begin
		tx_clk = 1'b0;
		mii_tx = '0;
		forever #62.5 tx_clk = ~tx_clk;
	end

	// Nibbles are random while disabled too, so nothing may depend on them then
	task automatic send_frame(input int len, input int gap);
		for (int i = 0; i < len + gap; i++) begin
			@(posedge tx_clk);
			mii_tx <= {1'(i < len), 4'($urandom)};
		end
	endtask
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// Purpose: Self-checking bench for the transmit coding path.
// Assumes: Line bits are descrambled with a bench copy of the scrambler.
// Notes:   Each line code-group is compared with one derived from the MII nibbles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin comparisons++; if ((ex) !== (gt)) begin error_cnt++; \
	$display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end
module testbench;
	logic                     mclk;
	logic                     sys_rst;
	logic                     tx_clk;
	tx_pcs_pkg::mii_tx_type   mii_tx;
	logic [4:0]               phy_address_straps;
	logic                     bypass_encoder;
	logic                     bypass_scrambler;
	tx_pcs_pkg::line_out_type line_out;
	int                       error_cnt = 0;
	int                       comparisons = 0;
	int                       cycles = 0;
	int                       grp_cnt = 0;
	int                       bit_cnt = 0;
	logic [10:0]              lfsr;
	logic [4:0]               shreg;
	logic [4:0]               eg;
	logic [1:0]               phase = 2'h0;
	logic [1:0]               est = 2'h0;
	logic                     bs_cur = 1'b0;
	logic                     rst_d = 1'b0;
	logic                     key;
	logic [4:0]               expq[$];
	localparam logic [15:0][4:0] CODES = {5'h1d, 5'h1c, 5'h1b, 5'h1a, 5'h17, 5'h16, 5'h13,
		5'h12, 5'h0f, 5'h0e, 5'h0b, 5'h0a, 5'h15, 5'h14, 5'h09, 5'h1e};

	mac_model mac_model_inst (.tx_clk(tx_clk), .mii_tx(mii_tx));
	fast_ethernet_tx_pcs_encoder fast_ethernet_tx_pcs_encoder_inst (.mclk(mclk),
		.sys_rst(sys_rst), .tx_clk(tx_clk), .mii_tx(mii_tx),
		.phy_address_straps(phy_address_straps), .bypass_encoder(bypass_encoder),
		.bypass_scrambler(bypass_scrambler), .line_out(line_out));

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// ********************
	// Expected code-groups
	// ********************
	// Code-group owed for one nibble in the given coder state
	function automatic logic [4:0] exp_group(input logic [1:0] st,
		input tx_pcs_pkg::mii_tx_type m, input logic byp);
		case (st)
			2'h0: return m.tx_en ? 5'h18 : 5'h1f;
			2'h1: return 5'h11;
			2'h2: return !m.tx_en ? 5'h0d : byp ? {1'b0, m.txd} : CODES[m.txd];
			default: return 5'h07;
		endcase
	endfunction

	// Read 1 ns after the edge so the model's new nibble is seen
	always @(posedge tx_clk) begin
		#1;
		if (!sys_rst) begin
			expq.push_back(exp_group(est, mii_tx, bypass_encoder));
			est = (est == 2'h0) ? 2'(mii_tx.tx_en) : (est == 2'h2 && mii_tx.tx_en) ? est : est + 2'h1;
		end
	end

	// ********************
	// Line monitor
	// ********************
	always @(posedge mclk) begin
		rst_d <= sys_rst;
		if (sys_rst) begin
			if (rst_d) `CHK("line_out in reset", 4'h0, line_out)
			lfsr = {phy_address_straps[4:1], tx_pcs_pkg::SEED_LOW};
			bit_cnt = 0;
			phase = 2'h0;
			est = 2'h0;
			expq.delete();
		end else if (line_out.bit_strobe === 1'b1) begin
			// Bypass is sampled per group; the bench only changes it between groups
			if (bit_cnt == 0) bs_cur = bypass_scrambler;
			key = lfsr[10] ^ lfsr[8];
			lfsr = {lfsr[9:0], key};
			shreg = {shreg[3:0], line_out.nrz_bit ^ (key & ~bs_cur)};
			phase = phase + 2'(line_out.nrz_bit);
			`CHK("drive_pos", phase == 2'h1, line_out.drive_pos)
			`CHK("drive_neg", phase == 2'h3, line_out.drive_neg)
			bit_cnt++;
			if (bit_cnt == 5) begin
				bit_cnt = 0;
				grp_cnt++;
				eg = (expq.size() > 0) ? expq.pop_front() : 5'h00;
				`CHK("code_group", eg, shreg)
			end
		end
	end

	task automatic finish_test();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 60000) begin
			error_cnt++;
			$display("MISMATCH run_time expected done seen timeout");
			finish_test();
		end
	end

	// ********************
	// Stimulus
	// ********************
	initial begin
		void'($urandom(86));
		sys_rst = 1'b1;
		phy_address_straps = 5'($urandom);
		bypass_encoder = 1'b0;
		bypass_scrambler = 1'b0;
		repeat (2) @(negedge mclk);
		sys_rst = 1'b0;
		for (int f = 0; f < 40; f++) begin
			if (f == 20) begin
				// Second reset with another seed, kept clear of the next nibble edge
				@(posedge tx_clk);
				#10;
				@(negedge mclk);
				phy_address_straps = ~phy_address_straps;
				sys_rst = 1'b1;
				repeat (3) @(negedge mclk);
				sys_rst = 1'b0;
			end
			mac_model_inst.send_frame(f < 2 ? 2 : 2 + $urandom_range(10),
				(f % 3 == 0) ? 2 : 2 + $urandom_range(3));
			@(grp_cnt);
			@(negedge mclk);
			{bypass_encoder, bypass_scrambler} = (f < 4) ? 2'h0 : 2'($urandom);
		end
		repeat (400) @(negedge mclk);
		finish_test();
	end
endmodule
`undef CHK
`default_nettype wire
